/* hw/skip_table_xor_regs.svh */
`ifndef SKIP_TABLE_XOR_REGS_SVH
`define SKIP_TABLE_XOR_REGS_SVH

// ------------------------------------------------------------
// Data widths and fixed values
// ------------------------------------------------------------
`define STX_BYTE_W 8
`define STX_BIT_SEL_W 3
`define STX_ZERO_BYTE 8'h00
`define STX_PTR_STEP 8'h01
`define STX_ACC_RST 8'h00
`define STX_PTR_LOW_RST 8'h00
`define STX_PTR_PAGE_RST 8'h00
`define STX_TBL_HIGH_RST 8'h00
`define STX_WORD_LOW_LSB 0
`define STX_WORD_HIGH_LSB 8

`endif

/* hw/skip_table_xor_pkg.sv */
package skip_table_xor_pkg;

    // ------------------------------------------------------------
    // Operations executed by this block
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NONE,
        OP_SKIP_IF_BYTE_ZERO,
        OP_COPY_SKIP_IF_ZERO,
        OP_SKIP_IF_BIT_ZERO,
        OP_TABLE_READ_SELECTED_PAGE,
        OP_TABLE_READ_LAST_PAGE,
        OP_INCR_TABLE_READ_SELECTED_PAGE,
        OP_INCR_TABLE_READ_LAST_PAGE,
        OP_XOR_INTO_ACCUMULATOR,
        OP_XOR_INTO_MEMORY
    } op_e;

    typedef enum {
        ST_IDLE,
        ST_OPERAND,
        ST_DUMMY
    } state_e;

endpackage

/* hw/skip_table_xor_ops.sv */
`include "skip_table_xor_regs.svh"

// Summary of operation
// - Whole-byte test skips the next instruction when the byte is zero.
// - A taken skip adds a dummy cycle, three cycles in total.
// - Copy variant loads the byte into the accumulator, skips on zero.
// - Bit test skips the next instruction when the selected bit is zero.
// - Selected-page read uses page and low pointer; low to memory.
// - Last-page read uses only the low pointer on the top page.
// - Incrementing selected-page read bumps the low pointer, then reads.
// - Incrementing last-page read bumps the low pointer, then reads.
// - XOR into accumulator writes the accumulator, updates only zero.
// - XOR into memory writes the byte back, updates only zero.
module skip_table_xor_ops #(
    parameter int DM_AW = 8,
    parameter int PM_AW = 12,
    parameter int PM_DW = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Decode stage request
    input wire logic START,
    input wire skip_table_xor_pkg::op_e OPCODE,
    input wire logic [DM_AW-1:0] OPERAND_ADDR,
    input wire logic [`STX_BIT_SEL_W-1:0] BIT_SEL,
    input wire logic [`STX_BYTE_W-1:0] ACC_IN,
    output logic BUSY,
    output logic DONE,
    output logic SKIP,
    // Data memory, read data valid in the same cycle as the address
    output logic [DM_AW-1:0] DM_ADDR,
    input wire logic [`STX_BYTE_W-1:0] DM_RD_DATA,
    output logic DM_WR_EN,
    output logic [`STX_BYTE_W-1:0] DM_WR_DATA,
    // Program memory, read data valid in the same cycle as the address
    output logic [PM_AW-1:0] PM_ADDR,
    input wire logic [PM_DW-1:0] PM_RD_DATA,
    // Accumulator and zero flag updates
    output logic ACC_LOAD,
    output logic [`STX_BYTE_W-1:0] ACC_DATA,
    output logic ZERO_LOAD,
    output logic ZERO_VALUE,
    // Table pointer and table high byte
    input wire logic PTR_LOW_LOAD,
    input wire logic PTR_PAGE_LOAD,
    input wire logic [`STX_BYTE_W-1:0] PTR_LOAD_DATA,
    output logic [`STX_BYTE_W-1:0] TABLE_PTR_LOW,
    output logic [`STX_BYTE_W-1:0] TABLE_PTR_PAGE,
    output logic [`STX_BYTE_W-1:0] TABLE_HIGH
);

    // ------------------------------------------------------------
    // Request capture
    // ------------------------------------------------------------
    localparam int PAGE_W = PM_AW - `STX_BYTE_W;

    skip_table_xor_pkg::state_e state_reg;
    skip_table_xor_pkg::op_e op_reg;
    logic [`STX_BIT_SEL_W-1:0] bit_reg;
    logic [`STX_BYTE_W-1:0] acc_reg;
    logic [`STX_BYTE_W-1:0] table_pointer_low_reg;
    logic [`STX_BYTE_W-1:0] table_pointer_page_reg;
    logic [`STX_BYTE_W-1:0] table_high_byte_reg;
    logic [`STX_BYTE_W-1:0] ptr_low_next;
    logic [PM_AW-1:0] pm_addr_next;
    logic accept;
    logic is_incr;
    logic is_last;
    logic skip_next;
    logic is_table;
    logic [`STX_BYTE_W-1:0] xor_val;
    logic [`STX_BYTE_W-1:0] word_low;
    logic [`STX_BYTE_W-1:0] word_high;

    assign accept = START && (state_reg == skip_table_xor_pkg::ST_IDLE);
    assign is_incr =
        (OPCODE == skip_table_xor_pkg::OP_INCR_TABLE_READ_SELECTED_PAGE) ||
        (OPCODE == skip_table_xor_pkg::OP_INCR_TABLE_READ_LAST_PAGE);
    assign is_last =
        (OPCODE == skip_table_xor_pkg::OP_TABLE_READ_LAST_PAGE) ||
        (OPCODE == skip_table_xor_pkg::OP_INCR_TABLE_READ_LAST_PAGE);

    // Eight-bit add wraps by itself; the page register is never touched
    assign ptr_low_next = is_incr ?
        table_pointer_low_reg + `STX_PTR_STEP :
        table_pointer_low_reg;

    always_comb begin
        if (is_last) begin
            pm_addr_next = {{PAGE_W{1'b1}}, ptr_low_next};
        end else begin
            pm_addr_next = {table_pointer_page_reg[PAGE_W-1:0],
                            ptr_low_next};
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_reg <= skip_table_xor_pkg::OP_NONE;
            bit_reg <= '0;
            acc_reg <= `STX_ACC_RST;
            DM_ADDR <= '0;
            PM_ADDR <= '0;
        end else if (accept) begin
            op_reg <= OPCODE;
            bit_reg <= BIT_SEL;
            acc_reg <= ACC_IN;
            DM_ADDR <= OPERAND_ADDR;
            PM_ADDR <= pm_addr_next;
        end
    end

    // ------------------------------------------------------------
    // Table pointer registers
    // ------------------------------------------------------------
    // An incrementing read wins over a core load in the same cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            table_pointer_low_reg <= `STX_PTR_LOW_RST;
        end else if (accept && is_incr) begin
            table_pointer_low_reg <= ptr_low_next;
        end else if (PTR_LOW_LOAD) begin
            table_pointer_low_reg <= PTR_LOAD_DATA;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            table_pointer_page_reg <= `STX_PTR_PAGE_RST;
        end else if (PTR_PAGE_LOAD) begin
            table_pointer_page_reg <= PTR_LOAD_DATA;
        end
    end

    assign TABLE_PTR_LOW = table_pointer_low_reg;
    assign TABLE_PTR_PAGE = table_pointer_page_reg;
    assign TABLE_HIGH = table_high_byte_reg;

    // ------------------------------------------------------------
    // Operand evaluation
    // ------------------------------------------------------------
    assign xor_val = acc_reg ^ DM_RD_DATA;
    assign word_low = PM_RD_DATA[`STX_WORD_LOW_LSB +: `STX_BYTE_W];
    assign word_high = PM_RD_DATA[`STX_WORD_HIGH_LSB +: `STX_BYTE_W];
    assign is_table =
        (op_reg == skip_table_xor_pkg::OP_TABLE_READ_SELECTED_PAGE) ||
        (op_reg == skip_table_xor_pkg::OP_TABLE_READ_LAST_PAGE) ||
        (op_reg == skip_table_xor_pkg::OP_INCR_TABLE_READ_SELECTED_PAGE) ||
        (op_reg == skip_table_xor_pkg::OP_INCR_TABLE_READ_LAST_PAGE);

    always_comb begin
        case (op_reg)
            skip_table_xor_pkg::OP_SKIP_IF_BYTE_ZERO,
            skip_table_xor_pkg::OP_COPY_SKIP_IF_ZERO: begin
                skip_next = (DM_RD_DATA == `STX_ZERO_BYTE);
            end
            skip_table_xor_pkg::OP_SKIP_IF_BIT_ZERO: begin
                skip_next = !DM_RD_DATA[bit_reg];
            end
            default: begin
                skip_next = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= skip_table_xor_pkg::ST_IDLE;
        end else begin
            case (state_reg)
                skip_table_xor_pkg::ST_IDLE: begin
                    if (accept) begin
                        state_reg <= skip_table_xor_pkg::ST_OPERAND;
                    end
                end
                skip_table_xor_pkg::ST_OPERAND: begin
                    if (skip_next) begin
                        // Dummy slot replaces the fetched instruction
                        state_reg <= skip_table_xor_pkg::ST_DUMMY;
                    end else begin
                        state_reg <= skip_table_xor_pkg::ST_IDLE;
                    end
                end
                skip_table_xor_pkg::ST_DUMMY: begin
                    state_reg <= skip_table_xor_pkg::ST_IDLE;
                end
                default: begin
                    state_reg <= skip_table_xor_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BUSY <= 1'b0;
            DONE <= 1'b0;
            SKIP <= 1'b0;
        end else begin
            BUSY <= accept ||
                (state_reg == skip_table_xor_pkg::ST_OPERAND && skip_next);
            DONE <= (state_reg == skip_table_xor_pkg::ST_DUMMY) ||
                (state_reg == skip_table_xor_pkg::ST_OPERAND && !skip_next);
            SKIP <= state_reg == skip_table_xor_pkg::ST_OPERAND &&
                skip_next;
        end
    end

    // ------------------------------------------------------------
    // Result write-back
    // ------------------------------------------------------------
    // Skip tests and table reads never drive the zero flag
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ACC_LOAD <= 1'b0;
            ACC_DATA <= `STX_ACC_RST;
            ZERO_LOAD <= 1'b0;
            ZERO_VALUE <= 1'b0;
            DM_WR_EN <= 1'b0;
            DM_WR_DATA <= `STX_ZERO_BYTE;
        end else begin
            ACC_LOAD <= 1'b0;
            ZERO_LOAD <= 1'b0;
            DM_WR_EN <= 1'b0;
            if (state_reg == skip_table_xor_pkg::ST_OPERAND) begin
                case (op_reg)
                    skip_table_xor_pkg::OP_COPY_SKIP_IF_ZERO: begin
                        ACC_LOAD <= 1'b1;
                        ACC_DATA <= DM_RD_DATA;
                    end
                    skip_table_xor_pkg::OP_XOR_INTO_ACCUMULATOR: begin
                        ACC_LOAD <= 1'b1;
                        ACC_DATA <= xor_val;
                        ZERO_LOAD <= 1'b1;
                        ZERO_VALUE <= (xor_val == `STX_ZERO_BYTE);
                    end
                    skip_table_xor_pkg::OP_XOR_INTO_MEMORY: begin
                        DM_WR_EN <= 1'b1;
                        DM_WR_DATA <= xor_val;
                        ZERO_LOAD <= 1'b1;
                        ZERO_VALUE <= (xor_val == `STX_ZERO_BYTE);
                    end
                    default: begin
                        if (is_table) begin
                            DM_WR_EN <= 1'b1;
                            DM_WR_DATA <= word_low;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            table_high_byte_reg <= `STX_TBL_HIGH_RST;
        end else if (state_reg == skip_table_xor_pkg::ST_OPERAND &&
                     is_table) begin
            table_high_byte_reg <= word_high;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_operand(skip_table_xor_pkg::op_e op);
        state_reg == skip_table_xor_pkg::ST_OPERAND && op_reg == op;
    endsequence

    sequence s_taken_skip;
        ##1 SKIP && BUSY && !DONE ##1 DONE && !BUSY;
    endsequence

    a_zero_byte_skip: assert property (
        s_operand(skip_table_xor_pkg::OP_SKIP_IF_BYTE_ZERO) |->
        BUSY && !DONE ##1 DONE != SKIP &&
        SKIP == $past(DM_RD_DATA == `STX_ZERO_BYTE) && !ZERO_LOAD)
        else $error("byte zero skip wrong");

    a_skip_three_cycles: assert property (
        accept ##1 skip_next |-> s_taken_skip)
        else $error("taken skip not three cycles");

    a_copy_to_acc: assert property (
        s_operand(skip_table_xor_pkg::OP_COPY_SKIP_IF_ZERO) |=>
        ACC_LOAD && ACC_DATA == $past(DM_RD_DATA) && !ZERO_LOAD &&
        SKIP == (ACC_DATA == `STX_ZERO_BYTE))
        else $error("copy and skip wrong");

    a_bit_skip: assert property (
        s_operand(skip_table_xor_pkg::OP_SKIP_IF_BIT_ZERO) |=>
        SKIP == !$past(DM_RD_DATA[bit_reg]) && !ZERO_LOAD)
        else $error("bit test skip wrong");

    a_table_write: assert property (
        state_reg == skip_table_xor_pkg::ST_OPERAND && is_table |=>
        DM_WR_EN && DM_WR_DATA == $past(word_low) &&
        TABLE_HIGH == $past(word_high) && !ZERO_LOAD && !ACC_LOAD)
        else $error("table read write-back wrong");

    a_last_page_addr: assert property (
        accept && OPCODE == skip_table_xor_pkg::OP_TABLE_READ_LAST_PAGE |=>
        PM_ADDR == {{PAGE_W{1'b1}}, $past(table_pointer_low_reg)})
        else $error("last page address wrong");

    a_incr_sel_addr: assert property (
        accept &&
        OPCODE == skip_table_xor_pkg::OP_INCR_TABLE_READ_SELECTED_PAGE |=>
        PM_ADDR[`STX_BYTE_W-1:0] == TABLE_PTR_LOW &&
        TABLE_PTR_LOW == $past(table_pointer_low_reg) + `STX_PTR_STEP)
        else $error("incrementing selected read wrong");

    a_incr_wrap: assert property (
        accept && is_last && is_incr && !PTR_PAGE_LOAD |=>
        PM_ADDR[PM_AW-1 -: PAGE_W] == {PAGE_W{1'b1}} &&
        TABLE_PTR_PAGE == $past(table_pointer_page_reg) &&
        TABLE_PTR_LOW == $past(ptr_low_next))
        else $error("incrementing last read wrong");

    a_xor_acc: assert property (
        s_operand(skip_table_xor_pkg::OP_XOR_INTO_ACCUMULATOR) |=>
        ACC_LOAD && ACC_DATA == ($past(acc_reg) ^ $past(DM_RD_DATA)) &&
        ZERO_LOAD && ZERO_VALUE == (ACC_DATA == `STX_ZERO_BYTE) && !DM_WR_EN)
        else $error("xor into accumulator wrong");

    a_xor_mem: assert property (
        s_operand(skip_table_xor_pkg::OP_XOR_INTO_MEMORY) |=>
        DM_WR_EN && DM_WR_DATA == ($past(acc_reg) ^ $past(DM_RD_DATA)) &&
        ZERO_LOAD && ZERO_VALUE == (DM_WR_DATA == `STX_ZERO_BYTE) && !ACC_LOAD)
        else $error("xor into memory wrong");

endmodule

/* sim/skip_table_xor_ops_tb_top.sv */
module skip_table_xor_ops_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    logic clk, rst, start, busy, done, skip, dm_wr_en;
    skip_table_xor_pkg::op_e opcode;
    logic [7:0] operand_addr, acc_in, dm_addr, dm_rd_data, dm_wr_data;
    logic [2:0] bit_sel;
    logic [11:0] pm_addr;
    logic [15:0] pm_rd_data;
    logic acc_load, zero_load, zero_value, ptr_low_load, ptr_page_load;
    logic [7:0] acc_data, ptr_load_data, table_ptr_low, table_ptr_page;
    logic [7:0] table_high;
    logic [7:0] dmem [256];
    logic [7:0] r_skip, r_done, r_wr, r_acc_ld, r_acc_d, r_z_ld, r_z_v;
    logic [7:0] r_busy;
    int n_fail, checked;

    // ----------------------------------------------------------
    // Memories
    // ----------------------------------------------------------
    // Program word mirrors its address, so a wrong page shows in the data
    assign pm_rd_data = {pm_addr[3:0], pm_addr[11:8], pm_addr[7:0]};
    assign dm_rd_data = dmem[dm_addr];

    skip_table_xor_ops i_dut (
        .CLK(clk), .RST(rst), .START(start), .OPCODE(opcode),
        .OPERAND_ADDR(operand_addr), .BIT_SEL(bit_sel), .ACC_IN(acc_in),
        .BUSY(busy), .DONE(done), .SKIP(skip), .DM_ADDR(dm_addr),
        .DM_RD_DATA(dm_rd_data), .DM_WR_EN(dm_wr_en),
        .DM_WR_DATA(dm_wr_data), .PM_ADDR(pm_addr),
        .PM_RD_DATA(pm_rd_data), .ACC_LOAD(acc_load), .ACC_DATA(acc_data),
        .ZERO_LOAD(zero_load), .ZERO_VALUE(zero_value),
        .PTR_LOW_LOAD(ptr_low_load), .PTR_PAGE_LOAD(ptr_page_load),
        .PTR_LOAD_DATA(ptr_load_data), .TABLE_PTR_LOW(table_ptr_low),
        .TABLE_PTR_PAGE(table_ptr_page), .TABLE_HIGH(table_high)
    );

    // ----------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Issues one instruction and records what each cycle shows
    task automatic run(input skip_table_xor_pkg::op_e op,
                       input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] acc);
        int k;
        r_skip = 8'h00;
        r_done = 8'h00;
        r_wr = 8'h00;
        r_acc_ld = 8'h00;
        // Markers that no legal result uses, so a missing strobe shows
        r_acc_d = 8'h5A;
        r_z_ld = 8'h00;
        r_z_v = 8'hEE;
        r_busy = 8'h00;
        @(posedge clk);
        start <= 1'b1;
        opcode <= op;
        operand_addr <= a;
        bit_sel <= b;
        acc_in <= acc;
        @(posedge clk);
        start <= 1'b0;
        for (k = 1; k <= 5 && r_done == 8'h00; k++) begin
            #1;
            if (skip === 1'b1) r_skip = 8'(k);
            if (busy === 1'b1) r_busy++;
            if (acc_load === 1'b1) begin
                r_acc_ld = 8'h01;
                r_acc_d = acc_data;
            end
            if (zero_load === 1'b1) begin
                r_z_ld = 8'h01;
                r_z_v = {7'h00, zero_value};
            end
            if (dm_wr_en === 1'b1) begin
                r_wr++;
                dmem[dm_addr] = dm_wr_data;
            end
            if (done === 1'b1) r_done = 8'(k);
            else @(posedge clk);
        end
        if (r_done == 8'h00) begin
            check("done seen", r_done, 8'h01);
            finish_test();
        end
    endtask

    task automatic load_ptr(input logic page, input logic [7:0] d);
        @(posedge clk);
        ptr_page_load <= page;
        ptr_low_load <= ~page;
        ptr_load_data <= d;
        @(posedge clk);
        ptr_page_load <= 1'b0;
        ptr_low_load <= 1'b0;
    endtask

    // ----------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------
    task automatic t_skip_byte();
        dmem[8'h10] = 8'h00;
        run(skip_table_xor_pkg::OP_SKIP_IF_BYTE_ZERO, 8'h10, 3'h0, 8'h00);
        check("skip cycle", r_skip, 8'h02);
        check("skip length", r_done, 8'h03);
        check("skip zero strobe", r_z_ld, 8'h00);
        check("skip busy cycles", r_busy, 8'h02);
        dmem[8'h11] = 8'h80;
        run(skip_table_xor_pkg::OP_SKIP_IF_BYTE_ZERO, 8'h11, 3'h0, 8'h00);
        check("no skip", r_skip, 8'h00);
        check("no skip length", r_done, 8'h02);
        check("no skip busy cycles", r_busy, 8'h01);
    endtask

    task automatic t_copy();
        dmem[8'h50] = 8'h00;
        run(skip_table_xor_pkg::OP_COPY_SKIP_IF_ZERO, 8'h50, 3'h0, 8'hFF);
        check("copy load", r_acc_ld, 8'h01);
        check("copy data", r_acc_d, 8'h00);
        check("copy skip", r_skip, 8'h02);
        check("copy length", r_done, 8'h03);
        check("copy zero strobe", r_z_ld, 8'h00);
        dmem[8'h51] = 8'h3C;
        run(skip_table_xor_pkg::OP_COPY_SKIP_IF_ZERO, 8'h51, 3'h0, 8'hFF);
        check("copy data nz", r_acc_d, 8'h3C);
        check("copy no skip", r_skip, 8'h00);
    endtask

    task automatic t_bit();
        int i;
        for (i = 0; i < 8; i++) begin
            dmem[8'h30] = ~(8'h01 << i);
            run(skip_table_xor_pkg::OP_SKIP_IF_BIT_ZERO, 8'h30, 3'(i), 8'h00);
            check("bit skip", r_skip, 8'h02);
            check("bit zero strobe", r_z_ld, 8'h00);
            dmem[8'h30] = 8'h01 << i;
            run(skip_table_xor_pkg::OP_SKIP_IF_BIT_ZERO, 8'h30, 3'(i), 8'h00);
            check("bit no skip", r_skip, 8'h00);
            check("bit length", r_done, 8'h02);
        end
    endtask

    task automatic t_table();
        load_ptr(1'b1, 8'h03);
        load_ptr(1'b0, 8'h45);
        run(skip_table_xor_pkg::OP_TABLE_READ_SELECTED_PAGE, 8'h20, 3'h0,
            8'h00);
        check("sel low", dmem[8'h20], 8'h45);
        check("sel high", table_high, 8'h53);
        check("sel writes", r_wr, 8'h01);
        check("sel zero strobe", r_z_ld, 8'h00);
        run(skip_table_xor_pkg::OP_TABLE_READ_LAST_PAGE, 8'h21, 3'h0, 8'h00);
        check("last low", dmem[8'h21], 8'h45);
        check("last high", table_high, 8'h5F);
        run(skip_table_xor_pkg::OP_INCR_TABLE_READ_SELECTED_PAGE, 8'h22,
            3'h0, 8'h00);
        check("incr pointer", table_ptr_low, 8'h46);
        check("incr sel low", dmem[8'h22], 8'h46);
        check("incr sel high", table_high, 8'h63);
        load_ptr(1'b0, 8'hFF);
        run(skip_table_xor_pkg::OP_INCR_TABLE_READ_LAST_PAGE, 8'h23, 3'h0,
            8'h00);
        check("wrap pointer", table_ptr_low, 8'h00);
        check("wrap page", table_ptr_page, 8'h03);
        check("incr last low", dmem[8'h23], 8'h00);
        check("incr last high", table_high, 8'h0F);
    endtask

    task automatic t_xor();
        dmem[8'h40] = 8'hA5;
        run(skip_table_xor_pkg::OP_XOR_INTO_ACCUMULATOR, 8'h40, 3'h0, 8'hA5);
        check("xor acc zero", r_acc_d, 8'h00);
        check("xor acc flag", r_z_v, 8'h01);
        check("xor acc strobe", r_z_ld, 8'h01);
        dmem[8'h41] = 8'hF0;
        run(skip_table_xor_pkg::OP_XOR_INTO_ACCUMULATOR, 8'h41, 3'h0, 8'h0F);
        check("xor acc data", r_acc_d, 8'hFF);
        check("xor acc nz", r_z_v, 8'h00);
        check("xor acc writes", r_wr, 8'h00);
        dmem[8'h42] = 8'h3C;
        run(skip_table_xor_pkg::OP_XOR_INTO_MEMORY, 8'h42, 3'h0, 8'h3C);
        check("xor mem zero", dmem[8'h42], 8'h00);
        check("xor mem flag", r_z_v, 8'h01);
        check("xor mem acc", r_acc_ld, 8'h00);
        dmem[8'h43] = 8'h02;
        run(skip_table_xor_pkg::OP_XOR_INTO_MEMORY, 8'h43, 3'h0, 8'h01);
        check("xor mem data", dmem[8'h43], 8'h03);
        check("xor mem nz", r_z_v, 8'h00);
    endtask

    // ----------------------------------------------------------
    // Clock, reset and main sequence
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        int i;
        n_fail = 0;
        checked = 0;
        rst = 1'b1;
        start = 1'b0;
        opcode = skip_table_xor_pkg::OP_NONE;
        operand_addr = 8'h00;
        bit_sel = 3'h0;
        acc_in = 8'h00;
        ptr_low_load = 1'b0;
        ptr_page_load = 1'b0;
        ptr_load_data = 8'h00;
        for (i = 0; i < 256; i++) dmem[i] = 8'hFF;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("reset busy", {7'h00, busy}, 8'h00);
        check("reset table high", table_high, 8'h00);
        t_skip_byte();
        t_copy();
        t_bit();
        t_table();
        t_xor();
        finish_test();
    end
endmodule
